// file: pkg/flash_cmd_pkg.sv
// constants shared by the serial flash end and the host controller end
// ----------------------------------------------------------------------
// Behaviour
// - 03h: three address bytes, then data out
// - 0Bh: address, one dummy byte, data out
// - read address increments, wraps to zero
// - select high ends read, even mid-byte
// - array reads refused while cycle runs
// - 06h sets the write latch
// - 04h clears the write latch
// - page write/program need latch, one data byte or more
// - DBh/D8h erase: address only, latch needed
// - latch cleared at reset and cycle end
// - latch clear: no write, program, erase
// - busy flag high while a cycle runs
// - 05h repeats status byte without end
// - 9Fh: identity, custom length, custom bytes
// - custom bytes read-only, zero by default
// - identity ignored while a cycle runs
// - select high ends identity, back to standby
// - latch commands: opcode only, then deselect
// - B9h enters, ABh leaves deep power-down
// - inputs on rising, outputs on falling edge
// - every byte travels msb first
// - modifying commands need whole bytes
// - deep power-down blocks write, program, erase
// ----------------------------------------------------------------------
package flash_cmd_pkg;
   // ----------------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------------
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDID = 8'h9f;
   localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FREAD = 8'h0b;
   localparam logic [7:0] OP_PWRITE = 8'h0a;
   localparam logic [7:0] OP_PPROG = 8'h02;
   localparam logic [7:0] OP_PERASE = 8'hdb;
   localparam logic [7:0] OP_SERASE = 8'hd8;
   localparam logic [7:0] OP_DPD = 8'hb9;
   localparam logic [7:0] OP_RDPD = 8'hab;
   // ----------------------------------------------------------------------
   // frame layout and identity sequence
   // ----------------------------------------------------------------------
   localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
   localparam logic [7:0] CUSTOM_LEN = 8'h10;
   localparam logic [4:0] ID_LAST = 5'h13;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   // ----------------------------------------------------------------------
   // host controller registers, byte addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_TX = 8'h08;
   localparam logic [7:0] REG_RX = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam int CTRL_HAS_ADDR = 8;
   localparam int CTRL_HAS_DUMMY = 9;
   localparam int CTRL_DIR_RD = 10;
   localparam int CTRL_CNT_LSB = 16;
   localparam logic [7:0] HALF_CLKS_DEF = 8'h06;
   // ----------------------------------------------------------------------
   // kinds of self-timed cycle
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {CYC_PWRITE, CYC_PPROG, CYC_PERASE, CYC_SERASE} cycle_kind_t;
endpackage

// file: pkg/spi_link_if.sv
// four-wire serial link between host controller and flash end
interface spi_link_if;
   logic sclk;
   logic sel_n;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic serial_out_lvl;
   // undriven output line floats high
   assign serial_out_lvl = serial_out_oe ? serial_out : 1'b1;
   modport host (
      output sclk,
      output sel_n,
      output serial_in,
      input serial_out_lvl
   );
   modport flash (
      input sclk,
      input sel_n,
      input serial_in,
      output serial_out,
      output serial_out_oe
   );
endinterface

// file: core/flash_end.sv
// command decoder and status logic of the serial flash end
module flash_end #(
   parameter logic [7:0] MAKER_ID = 8'h5a,   // arbitrary value
   parameter logic [7:0] TYPE_ID = 8'h3c,    // arbitrary value
   parameter logic [7:0] CAP_ID = 8'h0f,     // arbitrary value
   parameter logic [127:0] CUSTOM_BYTES = 128'h0
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   spi_link_if.flash link,
   output logic [23:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic op_start,
   output flash_cmd_pkg::cycle_kind_t op_kind,
   output logic [23:0] op_addr,
   output logic [7:0] wr_byte,
   output logic wr_strobe,
   input wire logic cycle_done,
   output logic deep_pd,
   output logic [7:0] status_flags
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DOUT, ST_DIN, ST_TAIL, ST_IGNORE
   } fstate_t;

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [1:0] sel_s;
      logic [1:0] din_s;
      fstate_t state;
      logic [2:0] bit_cnt;
      logic [2:0] ocnt;
      logic [1:0] byte_cnt;
      logic [4:0] id_idx;
      logic [7:0] sh_in;
      logic [7:0] sh_out;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [23:0] mem_addr;
      logic out_bit;
      logic oe;
      logic pend;
      logic write_latch_flag;
      logic busy;
      logic dpd;
      logic op_start;
      flash_cmd_pkg::cycle_kind_t op_kind;
      logic [7:0] wr_byte;
      logic wr_strobe;
   } fstate_all_t;

   fstate_all_t s_r;
   fstate_all_t s_nxt;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // byte k of the identity sequence, zero beyond its end
   function automatic logic [7:0] id_byte(input logic [4:0] idx);
      logic [7:0] b;
      b = 8'h00;
      if (idx == 5'h00) begin
         b = MAKER_ID;
      end else if (idx == 5'h01) begin
         b = TYPE_ID;
      end else if (idx == 5'h02) begin
         b = CAP_ID;
      end else if (idx == 5'h03) begin
         b = flash_cmd_pkg::CUSTOM_LEN;
      end else if (idx <= flash_cmd_pkg::ID_LAST) begin
         b = CUSTOM_BYTES[8'd127 - 8'({idx - 5'h04, 3'h0}) -: 8];
      end
      return b;
   endfunction

   // true for commands that start a self-timed cycle
   function automatic logic is_modify(input logic [7:0] op);
      return (op == flash_cmd_pkg::OP_PWRITE) || (op == flash_cmd_pkg::OP_PPROG)
         || (op == flash_cmd_pkg::OP_PERASE) || (op == flash_cmd_pkg::OP_SERASE);
   endfunction

   logic sck_rise;
   logic sck_fall;
   logic sel_hi;
   logic din;
   logic [7:0] in_byte;
   logic [7:0] stat_byte;
   logic [7:0] out_byte;

   // edges found on the synchronised serial clock
   assign sck_rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
   assign sck_fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
   assign sel_hi = s_r.sel_s[1];
   assign din = s_r.din_s[1];
   assign in_byte = {s_r.sh_in[6:0], din};

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sclk_s = {s_r.sclk_s[1:0], link.sclk};
      s_nxt.sel_s = {s_r.sel_s[0], link.sel_n};
      s_nxt.din_s = {s_r.din_s[0], link.serial_in};
      s_nxt.op_start = 1'b0;
      s_nxt.wr_strobe = 1'b0;
      stat_byte = 8'h00;
      stat_byte[flash_cmd_pkg::STAT_BUSY_BIT] = s_r.busy;
      stat_byte[flash_cmd_pkg::STAT_WEL_BIT] = s_r.write_latch_flag;
      out_byte = mem_rdata;
      if (s_r.opcode == flash_cmd_pkg::OP_STATUS_READ_CMD) begin
         out_byte = stat_byte;
      end else if (s_r.opcode == flash_cmd_pkg::OP_RDID) begin
         out_byte = id_byte(s_r.id_idx);
      end
      // end of a self-timed cycle
      if (cycle_done) begin
         s_nxt.busy = 1'b0;
         s_nxt.write_latch_flag = 1'b0;
      end
      if (sel_hi) begin
         // deselect: commit whole-byte commands, drop everything else
         if (s_r.state != ST_IDLE && s_r.pend && s_r.bit_cnt == 3'h0) begin
            unique case (s_r.opcode)
               flash_cmd_pkg::OP_WREN: s_nxt.write_latch_flag = 1'b1;
               flash_cmd_pkg::OP_WRDI: s_nxt.write_latch_flag = 1'b0;
               flash_cmd_pkg::OP_DPD: s_nxt.dpd = 1'b1;
               flash_cmd_pkg::OP_RDPD: s_nxt.dpd = 1'b0;
               flash_cmd_pkg::OP_PWRITE: s_nxt.op_kind = flash_cmd_pkg::CYC_PWRITE;
               flash_cmd_pkg::OP_PPROG: s_nxt.op_kind = flash_cmd_pkg::CYC_PPROG;
               flash_cmd_pkg::OP_PERASE: s_nxt.op_kind = flash_cmd_pkg::CYC_PERASE;
               flash_cmd_pkg::OP_SERASE: s_nxt.op_kind = flash_cmd_pkg::CYC_SERASE;
               default: s_nxt.dpd = s_r.dpd;
            endcase
            if (is_modify(s_r.opcode)) begin
               s_nxt.op_start = 1'b1;
               s_nxt.busy = 1'b1;
            end
         end
         s_nxt.state = ST_IDLE;
         s_nxt.oe = 1'b0;
         s_nxt.pend = 1'b0;
         s_nxt.bit_cnt = 3'h0;
      end else begin
         if (s_r.state == ST_IDLE) begin
            s_nxt.state = ST_OPC;
            s_nxt.bit_cnt = 3'h0;
            s_nxt.byte_cnt = 2'h0;
         end
         // capture on rising edges
         if (sck_rise && s_r.state != ST_IDLE) begin
            s_nxt.sh_in = in_byte;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.state == ST_TAIL) begin
               s_nxt.pend = 1'b0;
            end
            if (s_r.bit_cnt == 3'h7) begin
               unique case (s_r.state)
                  ST_OPC: begin
                     s_nxt.opcode = in_byte;
                     s_nxt.state = ST_IGNORE;
                     s_nxt.ocnt = 3'h0;
                     s_nxt.id_idx = 5'h00;
                     unique case (in_byte)
                        flash_cmd_pkg::OP_READ, flash_cmd_pkg::OP_FREAD: begin
                           if (!s_r.busy) begin
                              s_nxt.state = ST_ADDR;
                           end
                        end
                        flash_cmd_pkg::OP_STATUS_READ_CMD: begin
                           s_nxt.state = ST_DOUT;
                           s_nxt.oe = 1'b1;
                        end
                        flash_cmd_pkg::OP_RDID: begin
                           if (!s_r.busy) begin
                              s_nxt.state = ST_DOUT;
                              s_nxt.oe = 1'b1;
                           end
                        end
                        flash_cmd_pkg::OP_WREN, flash_cmd_pkg::OP_WRDI,
                        flash_cmd_pkg::OP_DPD, flash_cmd_pkg::OP_RDPD: begin
                           s_nxt.state = ST_TAIL;
                           s_nxt.pend = 1'b1;
                        end
                        flash_cmd_pkg::OP_PWRITE, flash_cmd_pkg::OP_PPROG,
                        flash_cmd_pkg::OP_PERASE, flash_cmd_pkg::OP_SERASE: begin
                           if (s_r.write_latch_flag && !s_r.busy && !s_r.dpd) begin
                              s_nxt.state = ST_ADDR;
                           end
                        end
                        default: s_nxt.state = ST_IGNORE;
                     endcase
                  end
                  ST_ADDR: begin
                     s_nxt.addr = {s_r.addr[15:0], in_byte};
                     s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
                     if (s_r.byte_cnt == flash_cmd_pkg::ADDR_BYTES_LAST) begin
                        s_nxt.mem_addr = {s_r.addr[15:0], in_byte};
                        if (s_r.opcode == flash_cmd_pkg::OP_READ) begin
                           s_nxt.state = ST_DOUT;
                           s_nxt.oe = 1'b1;
                        end else if (s_r.opcode == flash_cmd_pkg::OP_FREAD) begin
                           s_nxt.state = ST_DUMMY;
                        end else if (s_r.opcode == flash_cmd_pkg::OP_PERASE
                                     || s_r.opcode == flash_cmd_pkg::OP_SERASE) begin
                           s_nxt.state = ST_TAIL;
                           s_nxt.pend = 1'b1;
                        end else begin
                           s_nxt.state = ST_DIN;
                        end
                     end
                  end
                  ST_DUMMY: begin
                     s_nxt.state = ST_DOUT;
                     s_nxt.oe = 1'b1;
                  end
                  ST_DIN: begin
                     s_nxt.wr_byte = in_byte;
                     s_nxt.wr_strobe = 1'b1;
                     s_nxt.pend = 1'b1;
                  end
                  default: s_nxt.state = s_r.state;
               endcase
            end
         end
         // drive on falling edges
         if (sck_fall && s_r.state == ST_DOUT) begin
            s_nxt.ocnt = s_r.ocnt + 3'h1;
            if (s_r.ocnt == 3'h0) begin
               s_nxt.out_bit = out_byte[7];
               s_nxt.sh_out = {out_byte[6:0], 1'b0};
               if (s_r.opcode == flash_cmd_pkg::OP_READ || s_r.opcode == flash_cmd_pkg::OP_FREAD) begin
                  s_nxt.mem_addr = s_r.mem_addr + 24'h1;
               end
               if (s_r.id_idx <= flash_cmd_pkg::ID_LAST) begin
                  s_nxt.id_idx = s_r.id_idx + 5'h01;
               end
            end else begin
               s_nxt.out_bit = s_r.sh_out[7];
               s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.sclk_s <= 3'h0;
         s_r.sel_s <= 2'h3;
         s_r.state <= ST_IDLE;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign link.serial_out = s_r.out_bit;
   assign link.serial_out_oe = s_r.oe;
   assign mem_addr = s_r.mem_addr;
   assign op_start = s_r.op_start;
   assign op_kind = s_r.op_kind;
   assign op_addr = s_r.addr;
   assign wr_byte = s_r.wr_byte;
   assign wr_strobe = s_r.wr_strobe;
   assign deep_pd = s_r.dpd;
   assign status_flags = {6'h00, s_r.write_latch_flag, s_r.busy};
endmodule

// file: core/flash_host.sv
// host controller end: register port in, serial frames out
module flash_host #(
   parameter logic [7:0] HALF_CLKS = flash_cmd_pkg::HALF_CLKS_DEF
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   spi_link_if.host link
);
   // half period must cover both synchronisers
   if (HALF_CLKS < 8'h04) begin : g_bad_half
      $error("HALF_CLKS below 4");
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_END, H_GAP} hstate_t;
   typedef struct packed {
      hstate_t st;
      logic [7:0] div;
      logic sclk;
      logic sel_n;
      logic mosi;
      logic [2:0] bit_cnt;
      logic [2:0] ph;
      logic [7:0] sh;
      logic [7:0] rxsh;
      logic [10:0] ctrl;
      logic [15:0] cnt;
      logic [23:0] faddr;
      logic [7:0] tx;
      logic tx_full;
      logic [7:0] rx;
      logic rx_full;
      logic [31:0] rdata;
      logic [1:0] miso_s;
   } hstate_all_t;
   hstate_all_t s_r;
   hstate_all_t s_nxt;

   // phase after the given one: 0 opcode, 1-3 address, 4 dummy, 5 data
   function automatic logic [2:0] next_ph(input logic [2:0] ph, input logic [10:0] c);
      logic [2:0] tail;
      tail = c[flash_cmd_pkg::CTRL_HAS_DUMMY] ? 3'h4 : 3'h5;
      if (ph == 3'h0) begin
         return c[flash_cmd_pkg::CTRL_HAS_ADDR] ? 3'h1 : tail;
      end else if (ph == 3'h3) begin
         return tail;
      end else if (ph == 3'h5) begin
         return 3'h5;
      end
      return ph + 3'h1;
   endfunction

   logic [7:0] nbyte;
   logic [15:0] rem;
   logic dir_rd;
   assign dir_rd = s_r.ctrl[flash_cmd_pkg::CTRL_DIR_RD];

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.miso_s = {s_r.miso_s[0], link.serial_out_lvl};
      s_nxt.rdata = 32'h0;
      nbyte = 8'h00;
      rem = (s_r.ph == 3'h5) ? s_r.cnt - 16'h1 : s_r.cnt;
      unique case (s_r.ph)
         3'h0: nbyte = s_r.ctrl[7:0];
         3'h1: nbyte = s_r.faddr[23:16];
         3'h2: nbyte = s_r.faddr[15:8];
         3'h3: nbyte = s_r.faddr[7:0];
         3'h5: nbyte = s_r.tx;
         default: nbyte = 8'h00;
      endcase
      unique case (s_r.st)
         H_IDLE: s_nxt.div = 8'h00;
         H_LOAD: begin
            // data bytes wait for software: tx filled or rx emptied
            if (s_r.ph != 3'h5 || (dir_rd ? !s_r.rx_full : s_r.tx_full)) begin
               s_nxt.sh = nbyte;
               s_nxt.mosi = nbyte[7];
               s_nxt.bit_cnt = 3'h0;
               s_nxt.div = HALF_CLKS;
               s_nxt.st = H_LOW;
               if (s_r.ph == 3'h5 && !dir_rd) begin
                  s_nxt.tx_full = 1'b0;
               end
            end
         end
         H_LOW: begin
            s_nxt.div = s_r.div - 8'h01;
            if (s_r.div == 8'h00) begin
               s_nxt.sclk = 1'b1;
               s_nxt.div = HALF_CLKS;
               s_nxt.st = H_HIGH;
            end
         end
         H_HIGH: begin
            s_nxt.div = s_r.div - 8'h01;
            if (s_r.div == 8'h00) begin
               s_nxt.sclk = 1'b0;
               s_nxt.rxsh = {s_r.rxsh[6:0], s_r.miso_s[1]};
               s_nxt.sh = {s_r.sh[6:0], 1'b0};
               s_nxt.mosi = s_r.sh[6];
               s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
               s_nxt.div = HALF_CLKS;
               s_nxt.st = H_LOW;
               if (s_r.bit_cnt == 3'h7) begin
                  s_nxt.ph = next_ph(s_r.ph, s_r.ctrl);
                  s_nxt.cnt = rem;
                  s_nxt.st = H_LOAD;
                  if (s_r.ph == 3'h5 && dir_rd) begin
                     s_nxt.rx = {s_r.rxsh[6:0], s_r.miso_s[1]};
                     s_nxt.rx_full = 1'b1;
                  end
                  // whole bytes only, then deselect
                  if (next_ph(s_r.ph, s_r.ctrl) == 3'h5 && rem == 16'h0) begin
                     s_nxt.st = H_END;
                  end
               end
            end
         end
         H_END: begin
            s_nxt.div = s_r.div - 8'h01;
            if (s_r.div == 8'h00) begin
               s_nxt.sel_n = 1'b1;
               s_nxt.div = HALF_CLKS;
               s_nxt.st = H_GAP;
            end
         end
         H_GAP: begin
            s_nxt.div = s_r.div - 8'h01;
            if (s_r.div == 8'h00) begin
               s_nxt.st = H_IDLE;
            end
         end
         default: s_nxt.st = H_IDLE;
      endcase
      // register reads, answered next cycle
      if (rd) begin
         unique case (addr)
            flash_cmd_pkg::REG_CTRL: s_nxt.rdata = {s_r.cnt, 5'h00, s_r.ctrl};
            flash_cmd_pkg::REG_ADDR: s_nxt.rdata = {8'h00, s_r.faddr};
            flash_cmd_pkg::REG_TX: s_nxt.rdata = {24'h0, s_r.tx};
            flash_cmd_pkg::REG_RX: begin
               s_nxt.rdata = {24'h0, s_r.rx};
               if (!(s_nxt.rx_full && !s_r.rx_full)) begin
                  s_nxt.rx_full = 1'b0;
               end
            end
            flash_cmd_pkg::REG_STAT:
               s_nxt.rdata = {29'h0, s_r.rx_full, s_r.tx_full, s_r.st != H_IDLE};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      // register writes; a frame starts only from idle
      if (wr) begin
         unique case (addr)
            flash_cmd_pkg::REG_CTRL: begin
               if (s_r.st == H_IDLE) begin
                  s_nxt.ctrl = wdata[10:0];
                  s_nxt.cnt = wdata[flash_cmd_pkg::CTRL_CNT_LSB +: 16];
                  s_nxt.ph = 3'h0;
                  s_nxt.sel_n = 1'b0;
                  s_nxt.st = H_LOAD;
               end
            end
            flash_cmd_pkg::REG_ADDR: s_nxt.faddr = wdata[23:0];
            flash_cmd_pkg::REG_TX: begin
               s_nxt.tx = wdata[7:0];
               s_nxt.tx_full = 1'b1;
            end
            default: s_nxt.faddr = s_nxt.faddr;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register and outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.sel_n <= 1'b1;
         s_r.st <= H_IDLE;
         s_r.miso_s <= 2'h3;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign link.sclk = s_r.sclk;
   assign link.sel_n = s_r.sel_n;
   assign link.serial_in = s_r.mosi;
   assign rdata = s_r.rdata;
endmodule

// file: dv/flash_link_properties.sv
// link timing properties between host end and flash end
module flash_link_properties (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic serial_out_lvl
);
   logic [7:0] rises_r;
   // ---
   // rising link clock edges in this frame
   // ---
   always_ff @(posedge ref_clk) begin
      if (srst || sel_n) rises_r <= 8'h0;
      else if (sclk && !$past(sclk) && rises_r != 8'hff) rises_r <= rises_r + 8'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_oe_drop: assert property (sel_n [*6] |-> !serial_out_oe)
      else $error("output driven while deselected");
   a_sclk_idle: assert property (sel_n |-> !sclk)
      else $error("link clock high while deselected");
   a_oe_after_opcode: assert property ($rose(serial_out_oe) |-> !sel_n && rises_r >= 8'h8)
      else $error("output enabled before whole opcode");
   a_out_on_fall: assert property
      (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !sclk)
      else $error("output bit changed while clock high");
   a_float_high: assert property (!serial_out_oe |-> serial_out_lvl)
      else $error("released line not high");
   a_sel_gap: assert property ($rose(sel_n) |-> sel_n [*8])
      else $error("frame gap too short");
   a_in_stable: assert property (!sel_n && sclk |-> $stable(serial_in))
      else $error("input bit moved while clock high");
   a_sclk_hold: assert property ($rose(sclk) |-> sclk [*4])
      else $error("link clock high phase too short");
endmodule

// file: dv/serial_flash_command_front_end_tb.sv
// bench: host end and flash end joined by the serial link
module serial_flash_command_front_end_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [10:0] c; logic [23:0] a; logic [2:0] n; logic [31:0] e;} row_t;
   logic ref_clk, srst, clk_en, wr, rd, cycle_done, op_start, deep_pd, wr_strobe;
   logic [7:0] addr, mem_rdata, status_flags, wr_byte, wr_seen;
   logic [31:0] wdata, rdata, q;
   logic [23:0] mem_addr, op_addr;
   logic [1:0] op_kind;
   int n_errors, checks_done, cyc, n_ops;
   // ordinary frames: control, address, byte count, bytes expected
   row_t rows[8] = '{'{11'h006, 0, 0, 0}, '{11'h405, 0, 2, 32'h02020000},
      '{11'h004, 0, 0, 0}, '{11'h405, 0, 1, 0}, '{11'h503, 24'h10, 2, 32'h10110000},
      '{11'h70b, 24'hfffffe, 3, 32'hfdfe0000}, '{11'h49f, 0, 4, 32'h5a3c0f10},
      '{11'h4ff, 0, 1, 32'hff000000}};
   spi_link_if link();
   flash_host #(.HALF_CLKS(8'h06)) i_flash_host (.ref_clk(ref_clk), .srst(srst),
      .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
   flash_end #(.MAKER_ID(8'h5a), .TYPE_ID(8'h3c), .CAP_ID(8'h0f)) i_flash_end (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .link(link), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
      .wr_byte(wr_byte), .wr_strobe(wr_strobe), .cycle_done(cycle_done), .deep_pd(deep_pd),
      .status_flags(status_flags));
   flash_link_properties i_flash_link_properties (.ref_clk(ref_clk), .srst(srst),
      .sclk(link.sclk), .sel_n(link.sel_n), .serial_in(link.serial_in),
      .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe),
      .serial_out_lvl(link.serial_out_lvl));
   // array data: address low byte plus top byte
   assign mem_rdata = mem_addr[7:0] + mem_addr[23:16];
   // clock, cycle budget, committed cycle count
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (op_start === 1'b1) n_ops++;
      if (wr_strobe === 1'b1) wr_seen <= wr_byte;
      if (cyc == 60000) begin
         n_errors++;
         print_verdict();
      end
   end
   task chk(string nm, logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 0;
      rd <= 0;
      #1 q = rdata;
   endtask
   // one frame: load address and control, then feed the write bytes or collect the read bytes
   task frame(row_t r);
      bus(1, 8'h04, {8'h0, r.a});
      bus(1, 8'h00, {13'h0, r.n, 5'h0, r.c});
      for (int i = 0; i < r.n; i++) begin
         q = 0;
         if (!r.c[10]) begin
            q = 2;
            while (q[1] !== 1'b0) bus(0, 8'h10, 0);
            bus(1, 8'h08, {24'h0, r.e[31-8*i -: 8]});
         end else begin
            while (q[2] !== 1'b1) bus(0, 8'h10, 0);
            bus(0, 8'h0c, 0);
            chk("rx byte", {24'h0, q[7:0]}, {24'h0, r.e[31-8*i -: 8]});
         end
      end
      q = 1;
      while (q[0] !== 1'b0) bus(0, 8'h10, 0);
   endtask
   task print_verdict();
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      {srst, wr, rd, cycle_done, addr, wdata} = 0;
      {srst, clk_en} = 2'h3;
      repeat (10) @(posedge ref_clk);
      srst <= 0;
      @(posedge ref_clk);
      chk("status", {24'h0, status_flags}, 0);
      foreach (rows[i]) frame(rows[i]);
      // erase, then a status read and refused reads while busy
      frame(rows[0]);
      frame('{11'h1db, 24'h100, 0, 0});
      frame('{11'h405, 0, 1, 32'h03000000});
      frame('{11'h503, 0, 1, 32'hff000000});
      frame('{11'h49f, 0, 1, 32'hff000000});
      // frozen clock enable: a finished cycle goes unseen
      @(posedge ref_clk) clk_en <= 0;
      @(posedge ref_clk) cycle_done <= 1;
      @(posedge ref_clk) cycle_done <= 0;
      @(posedge ref_clk) clk_en <= 1;
      frame('{11'h405, 0, 1, 32'h03000000});
      @(posedge ref_clk) cycle_done <= 1;
      @(posedge ref_clk) cycle_done <= 0;
      frame(rows[3]);
      frame('{11'h1d8, 0, 0, 0});
      frame('{11'h0b9, 0, 0, 0});
      chk("deep_pd", deep_pd, 1);
      frame(rows[0]);
      frame('{11'h1d8, 0, 0, 0});
      frame('{11'h0ab, 0, 0, 0});
      chk("deep_pd", deep_pd, 0);
      chk("ops", n_ops, 1);
      // page program of one byte with the latch still set
      frame('{11'h102, 24'h345, 1, 32'ha5000000});
      chk("wr_byte", {24'h0, wr_seen}, 32'ha5);
      chk("op_addr", {8'h0, op_addr}, 32'h345);
      chk("op_kind", {30'h0, op_kind}, {30'h0, flash_cmd_pkg::CYC_PPROG});
      chk("ops", n_ops, 2);
      print_verdict();
   end
endmodule
